// File: rtl/mss_defs.svh
// Constants for the motor stop mode select block: register map, field layout, reset values, timing.
// Assumes inclusion by bare name from the block's design files.
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

`define MSS_CLK_PERIOD_NS   10
`define MSS_MS_IN_PS        1000000000
`define MSS_CLK_PERIOD_PS   10000
`define MSS_CYC_PER_MS      (`MSS_MS_IN_PS / `MSS_CLK_PERIOD_PS)

`define MSS_ADDR_STOP_SEL   8'h00
`define MSS_ADDR_TORQUE     8'h04
`define MSS_ADDR_DECEL_TIME 8'h08
`define MSS_ADDR_APPLY      8'h0c
`define MSS_ADDR_STATUS     8'h10
`define MSS_ADDR_ACTIVE     8'h14

`define MSS_F_SO_LSB        0
`define MSS_F_SO_MSB        1
`define MSS_F_SC_LSB        2
`define MSS_F_SC_MSB        3
`define MSS_F_EXT_LSB       4
`define MSS_F_EXT_MSB       6
`define MSS_F_FH_LSB        8
`define MSS_F_FH_MSB        10
`define MSS_F_SENSE         12
`define MSS_F_APPLY         0

`define MSS_SO_DYN          2'h0
`define MSS_SO_DYN_FREE     2'h1
`define MSS_SO_FREE         2'h2
`define MSS_SC_ZERO         2'h0
`define MSS_SC_AS_SO        2'h1
`define MSS_SC_EXT          2'h2
`define MSS_EXT_AS_SO       3'h0
`define MSS_EXT_TRQ_SO      3'h1
`define MSS_EXT_TRQ_FREE    3'h2
`define MSS_EXT_TIME_SO     3'h3
`define MSS_EXT_TIME_FREE   3'h4

`define MSS_RST_SO          2'h0
`define MSS_RST_SC          2'h1
`define MSS_RST_EXT         3'h1
`define MSS_RST_FH          3'h1
`define MSS_RST_SENSE       1'h0
`define MSS_RST_TORQUE      10'h320
`define MSS_MAX_TORQUE      10'h320
`define MSS_RST_DECEL_MS    14'h0000
`define MSS_MAX_DECEL_MS    14'h2710

`endif

// File: rtl/mss_pkg.sv
// Types shared by the motor stop mode select block.
// Assumes nothing beyond a SystemVerilog compiler.
package mss_pkg;

	typedef enum logic [2:0]
	{
		mss_run,
		mss_zero_hold,
		mss_decel,
		mss_dyn_brake,
		mss_dyn_then_free,
		mss_free
	} mss_state_t;

	typedef enum logic [2:0]
	{
		mss_cause_none,
		mss_cause_main_power,
		mss_cause_ctrl_power,
		mss_cause_forced_halt,
		mss_cause_servo_off,
		mss_cause_second_class
	} mss_cause_t;

endpackage

// File: rtl/mss_sync.sv
// Two flip-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are levels that stay put for several clock cycles.
`timescale 1ns/1ps
module mss_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             pclk,    // Block clock.
	input  wire logic             presetn, // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] async_in, // Raw levels from pins.
	output logic      [WIDTH-1:0] sync_out  // Levels safe to read in pclk domain.
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1   <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule // mss_sync

// File: rtl/mss_stop_select.sv
// Motor stop mode select: picks how the power stage halts the motor and the rotation sense, APB registers.
// Assumes an APB master on pclk, stop causes from pins, and motor_stopped from speed logic on pclk.
// Summary of operation
// - Servo-off selector: 0 dynamic brake, 1 brake then free, 2 free; default 0.
// - Servo off and first-class alarm share the servo-off selector.
// - Second-class alarm uses its own selector.
// - Second-class selector: 0 zero speed, 1 as servo off, 2 extended; default 1.
// - Extended selector counts only when second-class selector is 2.
// - Forced-halt input stops per forced-halt selector, default 1.
// - Extended and forced-halt values 1 and 2 decelerate under common stop torque.
// - Values 3 and 4 decelerate within the common deceleration stop time.
// - Value 0 acts as servo off; 1 and 3 servo off after; 2, 4 free after.
// - In torque control every stop other than power loss follows the servo-off selector.
// - Main power loss always gives a dynamic braking stop.
// - Control power loss brakes dynamically, except one high-power variant which coasts.
// - Rotation sense: 0 counter-clockwise, 1 clockwise for positive command; default 0.
// - Clockwise means clockwise seen from the motor shaft end.
// - Common stop torque is percent of rated, 0 to 800, default 800, clamped.
// - Deceleration stop time from maximum speed, 0 to 10000 ms; 0 stops at once.
`timescale 1ns/1ps
`include "mss_defs.svh"
module mss_stop_select
#(
	parameter int  CYC_PER_MS         = `MSS_CYC_PER_MS,
	parameter bit  HIGH_POWER_VARIANT = 1'b0
)
(
	input  wire logic        pclk,               // Block clock, 100 MHz.
	input  wire logic        presetn,            // Asynchronous reset, active low.
	input  wire logic        psel,               // APB select.
	input  wire logic        penable,            // APB enable.
	input  wire logic        pwrite,             // APB write.
	input  wire logic [7:0]  paddr,              // APB byte address.
	input  wire logic [31:0] pwdata,             // APB write data.
	output logic      [31:0] prdata,             // APB read data.
	output logic             pready,             // APB ready.
	output logic             pslverr,            // APB error on unmapped address.
	input  wire logic        servo_off_req,      // Servo off request pin.
	input  wire logic        first_class_alarm,  // First-class alarm pin.
	input  wire logic        second_class_alarm, // Second-class alarm pin.
	input  wire logic        forced_halt_input,  // Forced-halt input pin.
	input  wire logic        main_power_lost,    // Main circuit power lost pin.
	input  wire logic        ctrl_power_lost,    // Control circuit power lost pin.
	input  wire logic        torque_mode,        // Torque control mode pin.
	input  wire logic        motor_stopped,      // Motor at standstill, from pclk logic.
	input  wire logic [9:0]  max_torque_pct,     // Motor maximum torque, percent of rated.
	input  wire logic [31:0] speed_cmd_in,       // Received signed speed command.
	input  wire logic [31:0] feedback_in,        // Encoder feedback for monitors.
	output logic             dyn_brake_on,       // Dynamic brake engaged.
	output logic             servo_energized,    // Power stage driving the motor.
	output logic             zero_speed_cmd,     // Speed command forced to zero.
	output logic             decel_active,       // Limited deceleration in progress.
	output logic             decel_by_time,      // Deceleration ruled by stop time.
	output logic      [9:0]  stop_torque_limit,  // Torque limit during deceleration.
	output logic      [13:0] decel_time_ms,      // Stop time from maximum speed.
	output logic      [31:0] motor_speed_cmd,    // Command to the power stage.
	output logic      [31:0] monitor_out,        // Feedback for encoder and analog monitors.
	output logic             rotation_reversed   // Active rotation sense is clockwise.
);

	logic [6:0]  pins_sync;
	logic        so_s;
	logic        fa_s;
	logic        sa_s;
	logic        fh_s;
	logic        mp_s;
	logic        cp_s;
	logic        tq_s;
	logic [1:0]  pend_so;
	logic [1:0]  pend_sc;
	logic [2:0]  pend_ext;
	logic [2:0]  pend_fh;
	logic        pend_sense;
	logic [1:0]  act_so;
	logic [1:0]  act_sc;
	logic [2:0]  act_ext;
	logic [2:0]  act_fh;
	logic        act_sense;
	logic [9:0]  torque_set;
	logic [13:0] time_set;
	logic        post_free;
	logic [31:0] prescale;
	logic [13:0] ms_count;
	mss_pkg::mss_state_t state;
	mss_pkg::mss_state_t next_state;
	mss_pkg::mss_cause_t cause;
	mss_pkg::mss_cause_t next_cause;
	logic        next_post_free;
	logic        next_by_time;

	mss_sync
	#(
		.WIDTH(7)
	)
	u_pin_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.async_in({torque_mode, ctrl_power_lost, main_power_lost, forced_halt_input,
		           second_class_alarm, first_class_alarm, servo_off_req}),
		.sync_out(pins_sync)
	);

	assign so_s = pins_sync[0];
	assign fa_s = pins_sync[1];
	assign sa_s = pins_sync[2];
	assign fh_s = pins_sync[3];
	assign mp_s = pins_sync[4];
	assign cp_s = pins_sync[5];
	assign tq_s = pins_sync[6];

	// APB decode; the slave answers in the access cycle with no wait states.
	wire acc        = psel && penable;
	wire wr         = acc && pwrite;
	wire hit_sel    = paddr == `MSS_ADDR_STOP_SEL;
	wire hit_trq    = paddr == `MSS_ADDR_TORQUE;
	wire hit_time   = paddr == `MSS_ADDR_DECEL_TIME;
	wire hit_apply  = paddr == `MSS_ADDR_APPLY;
	wire hit_status = paddr == `MSS_ADDR_STATUS;
	wire hit_active = paddr == `MSS_ADDR_ACTIVE;
	wire mapped     = hit_sel | hit_trq | hit_time | hit_apply | hit_status | hit_active;
	wire do_apply   = wr && hit_apply && pwdata[`MSS_F_APPLY];
	wire [9:0]  wr_trq  = (pwdata > 32'(`MSS_MAX_TORQUE)) ? `MSS_MAX_TORQUE : pwdata[9:0];
	wire [13:0] wr_time = (pwdata > 32'(`MSS_MAX_DECEL_MS)) ? `MSS_MAX_DECEL_MS : pwdata[13:0];

	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	wire [31:0] rd_sel = {19'h00000, pend_sense, 1'b0, pend_fh, 1'b0, pend_ext, pend_sc, pend_so};
	wire [31:0] rd_act = {19'h00000, act_sense, 1'b0, act_fh, 1'b0, act_ext, act_sc, act_so};
	wire [31:0] rd_sts = {23'h000000, decel_by_time, 2'h0, cause, state};
	assign prdata = hit_sel    ? rd_sel :
	                hit_trq    ? {22'h000000, torque_set} :
	                hit_time   ? {18'h00000, time_set} :
	                hit_status ? rd_sts :
	                hit_active ? rd_act : 32'h00000000;

	// Pending selectors are written freely; the active copy follows only on an apply write while in run.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_so    <= `MSS_RST_SO;
			pend_sc    <= `MSS_RST_SC;
			pend_ext   <= `MSS_RST_EXT;
			pend_fh    <= `MSS_RST_FH;
			pend_sense <= `MSS_RST_SENSE;
		end
		else if (wr && hit_sel)
		begin
			pend_so    <= pwdata[`MSS_F_SO_MSB:`MSS_F_SO_LSB];
			pend_sc    <= pwdata[`MSS_F_SC_MSB:`MSS_F_SC_LSB];
			pend_ext   <= pwdata[`MSS_F_EXT_MSB:`MSS_F_EXT_LSB];
			pend_fh    <= pwdata[`MSS_F_FH_MSB:`MSS_F_FH_LSB];
			pend_sense <= pwdata[`MSS_F_SENSE];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_so    <= `MSS_RST_SO;
			act_sc    <= `MSS_RST_SC;
			act_ext   <= `MSS_RST_EXT;
			act_fh    <= `MSS_RST_FH;
			act_sense <= `MSS_RST_SENSE;
		end
		else if (do_apply && state == mss_pkg::mss_run)
		begin
			act_so    <= pend_so;
			act_sc    <= pend_sc;
			act_ext   <= pend_ext;
			act_fh    <= pend_fh;
			act_sense <= pend_sense;
		end
	end

	// Torque and stop time take effect at once.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			torque_set <= `MSS_RST_TORQUE;
			time_set   <= `MSS_RST_DECEL_MS;
		end
		else
		begin
			if (wr && hit_trq)
				torque_set <= wr_trq;
			if (wr && hit_time)
				time_set <= wr_time;
		end
	end

	// Servo-off behaviour, shared by servo off and first-class alarms.
	function automatic mss_pkg::mss_state_t so_target(input logic [1:0] sel);
		unique case (sel)
			`MSS_SO_DYN_FREE: so_target = mss_pkg::mss_dyn_then_free;
			`MSS_SO_FREE:     so_target = mss_pkg::mss_free;
			default:          so_target = mss_pkg::mss_dyn_brake;
		endcase
	endfunction

	wire mss_pkg::mss_state_t so_state = so_target(act_so);

	// Extended-style selector decode shared by second-class extended and forced halt.
	wire [2:0] ext_eff   = act_ext;
	wire       use_ext   = act_sc == `MSS_SC_EXT;
	wire [2:0] sc_code   = use_ext ? ext_eff : `MSS_EXT_AS_SO;
	wire [2:0] halt_code = fh_s ? act_fh : sc_code;
	wire       code_decel = (halt_code >= `MSS_EXT_TRQ_SO) && (halt_code <= `MSS_EXT_TIME_FREE);
	wire       code_time  = (halt_code == `MSS_EXT_TIME_SO) || (halt_code == `MSS_EXT_TIME_FREE);
	wire       code_free  = (halt_code == `MSS_EXT_TRQ_FREE) || (halt_code == `MSS_EXT_TIME_FREE);
	wire       sc_zero    = !fh_s && act_sc == `MSS_SC_ZERO;
	wire       any_stop   = so_s | fa_s | sa_s | fh_s;
	wire       power_loss = mp_s | cp_s;
	wire mss_pkg::mss_state_t power_state = (!mp_s && HIGH_POWER_VARIANT) ? mss_pkg::mss_free
	                                                                        : mss_pkg::mss_dyn_brake;
	wire mss_pkg::mss_cause_t start_cause = fh_s           ? mss_pkg::mss_cause_forced_halt :
	                                        (so_s || fa_s) ? mss_pkg::mss_cause_servo_off :
	                                                         mss_pkg::mss_cause_second_class;
	wire ext_path   = fh_s || (!so_s && !fa_s);
	wire time_done  = ms_count >= time_set;
	wire decel_done = motor_stopped || (decel_by_time && time_done);

	always_comb
	begin
		next_state     = state;
		next_cause     = cause;
		next_post_free = post_free;
		next_by_time   = decel_by_time;
		if (power_loss)
		begin
			next_state = power_state;
			next_cause = mp_s ? mss_pkg::mss_cause_main_power : mss_pkg::mss_cause_ctrl_power;
		end
		else
		begin
			unique case (state)
				mss_pkg::mss_run:
				begin
					if (any_stop)
					begin
						next_cause = start_cause;
						if (tq_s || !ext_path)
							next_state = so_state;
						else if (sc_zero)
							next_state = mss_pkg::mss_zero_hold;
						else if (code_decel)
						begin
							next_state     = mss_pkg::mss_decel;
							next_post_free = code_free;
							next_by_time   = code_time;
						end
						else
							next_state = so_state;
					end
				end
				mss_pkg::mss_decel:
				begin
					if (decel_done)
						next_state = post_free ? mss_pkg::mss_free : so_state;
				end
				mss_pkg::mss_dyn_then_free:
				begin
					if (motor_stopped)
						next_state = mss_pkg::mss_free;
				end
				default:
				begin
					if (!any_stop)
					begin
						next_state = mss_pkg::mss_run;
						next_cause = mss_pkg::mss_cause_none;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state         <= mss_pkg::mss_run;
			cause         <= mss_pkg::mss_cause_none;
			post_free     <= 1'b0;
			decel_by_time <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			cause         <= next_cause;
			post_free     <= next_post_free;
			decel_by_time <= next_by_time;
		end
	end

	// Millisecond timer for the time-limited deceleration; restarts on each entry.
	wire ms_tick = prescale == 32'(CYC_PER_MS - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prescale <= 32'h00000000;
			ms_count <= 14'h0000;
		end
		else if (state != mss_pkg::mss_decel)
		begin
			prescale <= 32'h00000000;
			ms_count <= 14'h0000;
		end
		else
		begin
			prescale <= ms_tick ? 32'h00000000 : prescale + 32'h00000001;
			if (ms_tick && !time_done)
				ms_count <= ms_count + 14'h0001;
		end
	end

	assign servo_energized = (state == mss_pkg::mss_run) || (state == mss_pkg::mss_zero_hold) ||
	                         (state == mss_pkg::mss_decel);
	assign dyn_brake_on    = (state == mss_pkg::mss_dyn_brake) || (state == mss_pkg::mss_dyn_then_free);
	assign zero_speed_cmd  = (state == mss_pkg::mss_zero_hold) || (state == mss_pkg::mss_decel);
	assign decel_active    = state == mss_pkg::mss_decel;
	assign rotation_reversed = act_sense;
	assign decel_time_ms   = time_set;

	// Command, torque limit and monitor copies are registered outputs.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			motor_speed_cmd   <= 32'h00000000;
			monitor_out       <= 32'h00000000;
			stop_torque_limit <= `MSS_RST_TORQUE;
		end
		else
		begin
			if (next_state != mss_pkg::mss_run)
				motor_speed_cmd <= 32'h00000000;
			else if (act_sense)
				motor_speed_cmd <= 32'h00000000 - speed_cmd_in;
			else
				motor_speed_cmd <= speed_cmd_in;
			monitor_out       <= feedback_in;
			stop_torque_limit <= (torque_set > max_torque_pct) ? max_torque_pct : torque_set;
		end
	end

endmodule // mss_stop_select

// File: bench/mss_motor_model.sv
// Behavioural motor and power stage that reports standstill a set time after a stop begins.
// Assumes stop indications from the stop select block on pclk.
`timescale 1ns/1ps
module mss_motor_model
(
	input  wire logic       pclk,            // Block clock.
	input  wire logic       presetn,         // Reset, active low.
	input  wire logic       servo_energized, // Stage drives the motor.
	input  wire logic       zero_speed_cmd,  // Command held at zero.
	input  wire logic       dyn_brake_on,    // Brake shorts the windings.
	input  wire logic [7:0] stop_delay,      // Cycles from stop to standstill.
	output logic            motor_stopped    // Shaft at rest.
);
	logic [7:0] coast_cnt;
	wire        stopping = !servo_energized || zero_speed_cmd || dyn_brake_on;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			coast_cnt <= 8'h00;
		else if (!stopping)
			coast_cnt <= 8'h00;
		else if (coast_cnt != 8'hff)
			coast_cnt <= coast_cnt + 8'h01;

	assign motor_stopped = stopping && (coast_cnt >= stop_delay);
endmodule // mss_motor_model

// File: bench/mss_stop_select_chk.sv
// Concurrent checks on the ports of the motor stop mode select block.
// Assumes pin inputs pass a two-stage synchroniser before the stop state sees them.
`timescale 1ns/1ps
module mss_stop_select_chk
#(
	parameter bit HIGH_POWER_VARIANT = 1'b0
)
(
	input wire logic        pclk,              // Block clock.
	input wire logic        presetn,           // Reset, active low.
	input wire logic        main_power_lost,   // Main power lost pin.
	input wire logic        ctrl_power_lost,   // Control power lost pin.
	input wire logic [9:0]  max_torque_pct,    // Motor maximum torque.
	input wire logic [31:0] speed_cmd_in,      // Received command.
	input wire logic [31:0] feedback_in,       // Encoder feedback.
	input wire logic        dyn_brake_on,      // Brake engaged.
	input wire logic        servo_energized,   // Stage driving.
	input wire logic        zero_speed_cmd,    // Command forced to zero.
	input wire logic        decel_active,      // Deceleration running.
	input wire logic        decel_by_time,     // Deceleration by time.
	input wire logic [9:0]  stop_torque_limit, // Deceleration torque.
	input wire logic [13:0] decel_time_ms,     // Stop time.
	input wire logic [31:0] motor_speed_cmd,   // Stage command.
	input wire logic [31:0] monitor_out,       // Monitor feedback.
	input wire logic        rotation_reversed  // Active sense.
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_main_held;
		main_power_lost[*4];
	endsequence
	sequence s_ctrl_held;
		ctrl_power_lost[*4] ##0 !main_power_lost;
	endsequence
	sequence s_driving;
		servo_energized && !zero_speed_cmd && !dyn_brake_on;
	endsequence

	chk_main_loss_brake: assert property (s_main_held |-> dyn_brake_on)
		else $error("main power loss without dynamic brake");
	chk_ctrl_loss_stop: assert property (s_ctrl_held |-> dyn_brake_on == !HIGH_POWER_VARIANT)
		else $error("control power loss stop kind wrong");
	chk_brake_unpowered: assert property (dyn_brake_on |-> !servo_energized)
		else $error("brake engaged while stage drives");
	chk_decel_zero_cmd: assert property (decel_active |-> zero_speed_cmd && servo_energized)
		else $error("deceleration without zero command");
	chk_torque_clamp: assert property ($past(presetn) && $stable(max_torque_pct)
		|-> stop_torque_limit <= max_torque_pct && stop_torque_limit <= 10'h320)
		else $error("stop torque above clamp");
	chk_monitor_copy: assert property ($past(presetn) |-> monitor_out == $past(feedback_in))
		else $error("monitor output altered");
	chk_sense_cmd: assert property (s_driving ##1 s_driving ##0 $stable(rotation_reversed) ##0 $past(presetn)
		|-> motor_speed_cmd == (rotation_reversed ? -$past(speed_cmd_in) : $past(speed_cmd_in)))
		else $error("speed command sense wrong");
	chk_stop_cmd_zero: assert property ((!servo_energized || zero_speed_cmd)[*2] |-> motor_speed_cmd == 32'h0)
		else $error("stopped but command not zero");
	chk_zero_time_exit: assert property (decel_active && decel_by_time && decel_time_ms == 14'h0
		|-> ##[1:2] !decel_active)
		else $error("zero stop time did not end deceleration");
endmodule // mss_stop_select_chk

bind mss_stop_select mss_stop_select_chk #(.HIGH_POWER_VARIANT(HIGH_POWER_VARIANT)) u_chk (.pclk, .presetn,
	.main_power_lost, .ctrl_power_lost, .max_torque_pct, .speed_cmd_in, .feedback_in, .dyn_brake_on,
	.servo_energized, .zero_speed_cmd, .decel_active, .decel_by_time, .stop_torque_limit, .decel_time_ms,
	.motor_speed_cmd, .monitor_out, .rotation_reversed);

// File: bench/motor_stop_mode_select_tb.sv
// Self-checking bench for the motor stop mode select block with a motor model on its outputs.
// Assumes the design, its package, its constants header and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module motor_stop_mode_select_tb;
	logic        pclk, presetn, psel, penable, pwrite, perr;
	logic        pready, pslverr, motor_stopped, torque_mode;
	logic        dyn_brake_on, servo_energized, zero_speed_cmd, decel_active, decel_by_time, rotation_reversed;
	logic [5:0]  pins;
	logic [7:0]  paddr, stop_delay;
	logic [9:0]  max_torque_pct, stop_torque_limit;
	logic [13:0] decel_time_ms;
	logic [31:0] pwdata, prdata, speed_cmd_in, feedback_in, rd, motor_speed_cmd, monitor_out;
	int          err_count = 0;
	int          n_checks = 0;
	int          seed = 32'h27cad36b;

	mss_stop_select #(.CYC_PER_MS(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .servo_off_req(pins[3]), .first_class_alarm(pins[5]), .second_class_alarm(pins[4]),
		.forced_halt_input(pins[2]), .main_power_lost(pins[0]), .ctrl_power_lost(pins[1]), .torque_mode,
		.motor_stopped, .max_torque_pct, .speed_cmd_in, .feedback_in, .dyn_brake_on, .servo_energized,
		.zero_speed_cmd, .decel_active, .decel_by_time, .stop_torque_limit, .decel_time_ms, .motor_speed_cmd,
		.monitor_out, .rotation_reversed);
	mss_motor_model u_motor (.pclk, .presetn, .servo_energized, .zero_speed_cmd, .dyn_brake_on, .stop_delay,
		.motor_stopped);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic end_sim;
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_count++;
			end_sim;
		end
	endtask

	function automatic logic cond(int k);
		case (k)
			0: return !servo_energized || zero_speed_cmd || dyn_brake_on;
			1: return !decel_active;
			default: return servo_energized && !zero_speed_cmd && !decel_active && !dyn_brake_on;
		endcase
	endfunction

	task automatic wt(int k);
		int n;
		n = 0;
		while (cond(k) !== 1'b1 && n < 300)
		begin
			@(posedge pclk);
			n++;
		end
		if (cond(k) !== 1'b1)
		begin
			err_count++;
			end_sim;
		end
	endtask

	// Returns the decel-by-time flag and the state code expected first or after the halt.
	function automatic logic [3:0] exp_st(int c, int so, int sc, int ext, int fh, int tq, int fin);
		int s;
		int v;
		s = (so == 0) ? 3 : (so == 1) ? 4 : 5;
		v = 0;
		if (c < 2)
			return 4'h3;
		if (tq == 0 && c == 2)
			v = fh;
		if (tq == 0 && c == 4 && sc == 0)
			return 4'h1;
		if (tq == 0 && c == 4 && sc == 2)
			v = ext;
		if (v < 1 || v > 4)
			return s[3:0];
		if (fin == 0)
			return {v > 2, 3'h2};
		// A torque-limited halt ends only at standstill, so brake-then-free releases at once.
		if (v == 1 && s == 4)
			return 4'h5;
		return (v % 2 == 0) ? 4'h5 : s[3:0];
	endfunction

	initial
	begin
		int c, k, so, sc, ext, fh, tq, dt, tqs, mt;
		logic [3:0] e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pins = 6'h00;
		torque_mode = 1'b0;
		stop_delay = 8'h10;
		max_torque_pct = 10'h320;
		speed_cmd_in = 32'h1234;
		feedback_in = 32'h5a5a;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0);
		`CHK(rd, 32'h114)
		apb(0, 8'h14, 0);
		`CHK(rd, 32'h114)
		apb(0, 8'h04, 0);
		`CHK(rd, 32'h320)
		apb(1, 8'h04, 32'h3ff);
		apb(0, 8'h04, 0);
		`CHK(rd, 32'h320)
		apb(1, 8'h08, 32'h3fff);
		apb(0, 8'h08, 0);
		`CHK(rd, 32'h2710)
		`CHK(decel_time_ms, 14'h2710)
		apb(0, 8'h1c, 0);
		`CHK({perr, rd}, {1'b1, 32'h0})
		apb(1, 8'h00, 32'h1115);
		`CHK(rotation_reversed, 1'b0)
		apb(1, 8'h0c, 32'h1);
		apb(0, 8'h14, 0);
		`CHK(rd, 32'h1115)
		`CHK({rotation_reversed, motor_speed_cmd}, {1'b1, 32'hffffedcc})
		`CHK(monitor_out, 32'h5a5a)
		for (int i = 0; i < 60; i++)
		begin
			c = i % 6;
			k = i / 6;
			so = $unsigned($random(seed)) % 3;
			sc = (k < 5) ? 2 : k % 3;
			ext = k % 5;
			fh = k % 5;
			tq = (k == 7);
			dt = (k == 9) ? 0 : 2 + $unsigned($random(seed)) % 2;
			tqs = $unsigned($random(seed)) % 801;
			mt = 100 + $unsigned($random(seed)) % 701;
			max_torque_pct <= mt[9:0];
			speed_cmd_in <= $random(seed);
			feedback_in <= $random(seed);
			stop_delay <= 8'(40 + $unsigned($random(seed)) % 20);
			torque_mode <= tq[0];
			apb(1, 8'h00, {19'h0, 1'($random(seed)), 1'b0, 3'(fh), 1'b0, 3'(ext), 2'(sc), 2'(so)});
			apb(1, 8'h0c, 32'h1);
			apb(1, 8'h04, 32'(tqs));
			apb(1, 8'h08, 32'(dt));
			pins <= 6'h01 << c;
			wt(0);
			e = exp_st(c, so, sc, ext, fh, tq, 0);
			if (dt != 0 || e[2:0] != 3'h2)
			begin
				apb(0, 8'h10, 0);
				`CHK(rd[5:0], {(c == 5) ? 3'h4 : 3'(c + 1), e[2:0]})
				if (e[2:0] == 3'h2)
					`CHK(decel_by_time, e[3])
				if (e[2:0] == 3'h2 && !e[3])
					`CHK(stop_torque_limit, 10'((tqs < mt) ? tqs : mt))
			end
			wt(1);
			e = exp_st(c, so, sc, ext, fh, tq, 1);
			apb(0, 8'h10, 0);
			`CHK(rd[2:0], e[2:0])
			if (e[2:0] == 3'h3)
				`CHK(dyn_brake_on, 1'b1)
			pins <= 6'h00;
			torque_mode <= 1'b0;
			wt(2);
		end
		end_sim;
	end
endmodule // motor_stop_mode_select_tb
